// ---- inc/cdr_pkg.sv ----
/*
 Shared constants and types for the control decoder and character rotator.
 Assumes one 250 MHz system clock and a synchronous active-low reset.
*/
package cdr_pkg;
	localparam int CODE_W = 5;
	localparam int LOW_W = 4;
	localparam int BANK_LINES = 16;
	localparam int CHAR_COUNT = 32;
	localparam int SF_COUNT = 4;
	localparam int CNT_W = 14;

	// Completion delay, in its own unit and as a clock count
	localparam int CLK_PERIOD_NS = 4;
	localparam int COMPLETE_DELAY_NS = 64000;
	localparam int COMPLETE_DELAY_CYC = COMPLETE_DELAY_NS / CLK_PERIOD_NS;

	localparam logic [CODE_W-1:0] CODE_NAK = 5'h15;
	localparam logic [CODE_W-1:0] CODE_US = 5'h1F;
	localparam logic BANK_LOWER = 1'b0;
	localparam logic BANK_UPPER = 1'b1;
	localparam logic [BANK_LINES-1:0] ONE_HOT_BASE = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;

	typedef logic [SF_COUNT-1:0][CODE_W-1:0] cdr_sf_map_t;
	// Factory strap set: BEL, HT, VT, FF onto lines 0..3
	localparam cdr_sf_map_t SF_MAP_DEFAULT = {5'h0C, 5'h0B, 5'h09, 5'h07};

	typedef enum logic [1:0] {ROT_0, ROT_90, ROT_180, ROT_270} cdr_rot_t;

	typedef struct packed {
		logic bank_select;
		logic [LOW_W-1:0] low_bits;
	} cdr_code_t;

	typedef struct packed {
		logic [3:0] row_sel;
		logic [2:0] col_sel_n;
	} cdr_glyph_t;

	typedef struct packed {
		logic rotated_shift_flag;
		logic [7:0] rotated_out;
	} cdr_stroke_t;

	typedef struct packed {
		cdr_rot_t rot;
		logic strobe_q;
		logic busy;
		logic [CNT_W-1:0] cnt;
		logic [CHAR_COUNT-1:0] ctrl_char;
		logic [SF_COUNT-1:0] special_func;
		logic control_complete;
		cdr_stroke_t stroke;
	} cdr_state_t;

	localparam cdr_stroke_t STROKE_RESET = '{rotated_shift_flag: 1'b1, rotated_out: 8'h00};
endpackage

// ---- core/cdr_bank.sv ----
/*
 One sixteen-line control-character decode bank.
 Assumes the caller gates enable with the execute strobe.
*/
module cdr_bank #(
	parameter logic BANK = 1'b0
) (
	input wire logic enable,
	input wire logic bank_select,
	input wire logic [cdr_pkg::LOW_W-1:0] low_bits,
	output logic [cdr_pkg::BANK_LINES-1:0] lines
);
	assign lines = (enable && bank_select == BANK) ? (cdr_pkg::ONE_HOT_BASE << low_bits) : '0;
endmodule // cdr_bank

// ---- core/cdr_top.sv ----
/*
 Control-character decoder with completion delay and character rotator.
 Assumes all inputs are synchronous to sys_clk and home/initialise are pulses or levels.
*/
// Behaviour
// - Bank bit picks lower or upper sixteen-line bank; low bits pick the line.
// - Decode lines are active only in the clock after the execute strobe is sampled high.
// - All five bits high under the strobe gives the US line.
// - Each special-function line follows a strap-selected control character.
// - Control complete rises 64 microseconds after an accepted strobe.
// - Bypass: rows to outputs 5-8, columns to 2-4, output 1 low, shift high.
// - Home, initialise or decoded US clear rotation to zero degrees.
// - Each accepted NAK strobe advances rotation 0, 90, 180, 270 unless home or initialise is active.
// - NAK after 270 wraps rotation to zero.
// - Zero degrees: shift high, rows to 5-8, columns to 2-4.
// - 90 degrees: shift low, rows to 1-4, columns to 6-8, output 5 low.
// - 180 degrees: shift low, output 1 low, rows to 8-5, columns to 4-2.
// - 270 degrees: shift low, rows to 4-1, columns to 8-6.
module cdr_top #(
	parameter int COMPLETE_DELAY = cdr_pkg::COMPLETE_DELAY_CYC,
	parameter cdr_pkg::cdr_sf_map_t SF_MAP = cdr_pkg::SF_MAP_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic control_execute_strobe,
	input wire cdr_pkg::cdr_code_t recv_code,
	input wire logic home_n,
	input wire logic initialise,
	input wire logic rotator_bypass,
	input wire cdr_pkg::cdr_glyph_t glyph,
	output logic [cdr_pkg::CHAR_COUNT-1:0] ctrl_char,
	output logic [cdr_pkg::SF_COUNT-1:0] special_func,
	output logic control_complete,
	output cdr_pkg::cdr_stroke_t stroke
);
	localparam logic [cdr_pkg::CNT_W-1:0] DELAY_LOAD = cdr_pkg::CNT_W'(COMPLETE_DELAY - 1);

	cdr_pkg::cdr_state_t state_reg;
	cdr_pkg::cdr_state_t state_next;
	logic [cdr_pkg::BANK_LINES-1:0] lower_lines;
	logic [cdr_pkg::BANK_LINES-1:0] upper_lines;
	logic [cdr_pkg::CHAR_COUNT-1:0] decoded;
	logic accept;

	////////////////////////////////////////////////////////////////////////////
	// Decode banks

	cdr_bank #(.BANK(cdr_pkg::BANK_LOWER)) u_lower (
		.enable(control_execute_strobe),
		.bank_select(recv_code.bank_select),
		.low_bits(recv_code.low_bits),
		.lines(lower_lines)
	);

	cdr_bank #(.BANK(cdr_pkg::BANK_UPPER)) u_upper (
		.enable(control_execute_strobe),
		.bank_select(recv_code.bank_select),
		.low_bits(recv_code.low_bits),
		.lines(upper_lines)
	);

	assign decoded = {upper_lines, lower_lines};
	assign accept = control_execute_strobe && !state_reg.strobe_q;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		state_next = state_reg;
		state_next.strobe_q = control_execute_strobe;
		state_next.ctrl_char = decoded;
		for (int i = 0; i < cdr_pkg::SF_COUNT; i++) begin
			state_next.special_func[i] = decoded[SF_MAP[i]];
		end

		// Completion timer
		state_next.control_complete = 1'b0;
		if (accept) begin
			state_next.busy = 1'b1;
			state_next.cnt = DELAY_LOAD;
		end else if (state_reg.busy) begin
			if (state_reg.cnt == cdr_pkg::CNT_ZERO) begin
				state_next.busy = 1'b0;
				state_next.control_complete = 1'b1;
			end else begin
				state_next.cnt = state_reg.cnt - cdr_pkg::CNT_ONE;
			end
		end

		// Rotation state; NAK and US act once per accepted strobe, home and initialise on any edge
		if (!home_n || initialise || (accept && decoded[cdr_pkg::CODE_US])) begin
			state_next.rot = cdr_pkg::ROT_0;
		end else if (accept && decoded[cdr_pkg::CODE_NAK]) begin
			unique case (state_reg.rot)
				cdr_pkg::ROT_0: state_next.rot = cdr_pkg::ROT_90;
				cdr_pkg::ROT_90: state_next.rot = cdr_pkg::ROT_180;
				cdr_pkg::ROT_180: state_next.rot = cdr_pkg::ROT_270;
				cdr_pkg::ROT_270: state_next.rot = cdr_pkg::ROT_0;
			endcase
		end

		// Stroke mapping; bit 0 is output 1
		state_next.stroke.rotated_out = '0;
		state_next.stroke.rotated_shift_flag = 1'b0;
		if (rotator_bypass) begin
			state_next.stroke.rotated_shift_flag = 1'b1;
			state_next.stroke.rotated_out[7:4] = glyph.row_sel;
			state_next.stroke.rotated_out[3:1] = glyph.col_sel_n;
		end else begin
			unique case (state_reg.rot)
				cdr_pkg::ROT_0: begin
					state_next.stroke.rotated_shift_flag = 1'b1;
					state_next.stroke.rotated_out[7:4] = glyph.row_sel;
					state_next.stroke.rotated_out[3:1] = glyph.col_sel_n;
				end
				cdr_pkg::ROT_90: begin
					state_next.stroke.rotated_out[3:0] = glyph.row_sel;
					state_next.stroke.rotated_out[7:5] = glyph.col_sel_n;
				end
				cdr_pkg::ROT_180: begin
					for (int i = 0; i < 4; i++) begin
						state_next.stroke.rotated_out[7-i] = glyph.row_sel[i];
					end
					for (int i = 0; i < 3; i++) begin
						state_next.stroke.rotated_out[3-i] = glyph.col_sel_n[i];
					end
				end
				cdr_pkg::ROT_270: begin
					for (int i = 0; i < 4; i++) begin
						state_next.stroke.rotated_out[3-i] = glyph.row_sel[i];
					end
					for (int i = 0; i < 3; i++) begin
						state_next.stroke.rotated_out[7-i] = glyph.col_sel_n[i];
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state_reg <= '{rot: cdr_pkg::ROT_0, strobe_q: 1'b0, busy: 1'b0, cnt: cdr_pkg::CNT_ZERO,
				ctrl_char: '0, special_func: '0, control_complete: 1'b0, stroke: cdr_pkg::STROKE_RESET};
		end else begin
			state_reg <= state_next;
		end
	end

	assign ctrl_char = state_reg.ctrl_char;
	assign special_func = state_reg.special_func;
	assign control_complete = state_reg.control_complete;
	assign stroke = state_reg.stroke;
endmodule // cdr_top

// ---- testbench/cdr_properties.sv ----
/*
 Port checker for cdr_top: decode, completion timing and rotation maps.
 Assumes the default strap map and a bind onto every cdr_top.
*/
module cdr_properties #(
	parameter int COMPLETE_DELAY = cdr_pkg::COMPLETE_DELAY_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic control_execute_strobe,
	input wire cdr_pkg::cdr_code_t recv_code,
	input wire logic home_n,
	input wire logic initialise,
	input wire logic rotator_bypass,
	input wire cdr_pkg::cdr_glyph_t glyph,
	input wire logic [31:0] ctrl_char,
	input wire logic [3:0] special_func,
	input wire logic control_complete,
	input wire cdr_pkg::cdr_stroke_t stroke
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam cdr_pkg::cdr_sf_map_t M = cdr_pkg::SF_MAP_DEFAULT;
	logic strobe_reg;
	logic accept;
	logic [15:0] wait_reg;
	assign accept = control_execute_strobe && !strobe_reg;
	// Counts edges since the latest accept, parked at zero when idle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			strobe_reg <= 1'b0;
			wait_reg <= 16'h0000;
		end else begin
			strobe_reg <= control_execute_strobe;
			wait_reg <= accept ? 16'h0001 : (wait_reg != 16'h0000 && wait_reg <= 16'(COMPLETE_DELAY)) ? wait_reg + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence nak_taken;
		accept && recv_code == cdr_pkg::CODE_NAK && home_n && !initialise;
	endsequence
	sequence cleared;
		initialise || !home_n;
	endsequence
	chk_idle_quiet: assert property (!$past(control_execute_strobe) |-> ctrl_char == 32'h00000000)
		else $error("decode active without strobe");
	chk_decode_index: assert property ($past(control_execute_strobe) && $past(nrst) |-> ctrl_char == 32'h00000001 << $past(recv_code))
		else $error("wrong decode line");
	chk_special_map: assert property (special_func == {ctrl_char[M[3]], ctrl_char[M[2]], ctrl_char[M[1]], ctrl_char[M[0]]})
		else $error("special line wrong");
	chk_complete_delay: assert property (control_complete == (wait_reg == 16'(COMPLETE_DELAY + 1)))
		else $error("completion at wrong edge");
	chk_complete_pulse: assert property (control_complete |=> !control_complete)
		else $error("completion too long");
	chk_bypass_map: assert property ($past(nrst) && $past(rotator_bypass) |-> stroke == {1'b1, $past(glyph), 1'b0})
		else $error("bypass map wrong");
	chk_clear_zero: assert property (cleared |-> ##2 stroke == {1'b1, $past(glyph), 1'b0})
		else $error("zero map after clear wrong");
	chk_nak_ninety: assert property (cleared ##1 nak_taken ##1 (home_n && !initialise && !rotator_bypass) |=>
		stroke == {1'b0, $past(glyph.col_sel_n), 1'b0, $past(glyph.row_sel)})
		else $error("ninety map wrong");
endmodule // cdr_properties
bind cdr_top cdr_properties #(.COMPLETE_DELAY(COMPLETE_DELAY)) chk_u (.sys_clk(sys_clk), .nrst(nrst),
	.control_execute_strobe(control_execute_strobe), .recv_code(recv_code), .home_n(home_n),
	.initialise(initialise), .rotator_bypass(rotator_bypass), .glyph(glyph), .ctrl_char(ctrl_char),
	.special_func(special_func), .control_complete(control_complete), .stroke(stroke));

// ---- testbench/cdr_char_gen.sv ----
/*
 Character generator matrix model: row and column index to select lines.
 Assumes indexes are held steady by the bench.
*/
module cdr_char_gen (
	input wire logic [3:0] row_idx,
	input wire logic [2:0] col_idx,
	output cdr_pkg::cdr_glyph_t glyph
);
	timeunit 1ns;
	timeprecision 1ps;
	// Column selects leave the matrix inverted
	assign glyph = '{row_sel: row_idx, col_sel_n: ~col_idx};
endmodule // cdr_char_gen

// ---- testbench/control_decode_char_rotator_tb.sv ----
/*
 Self-checking bench for cdr_top with a short completion delay.
 Assumes cdr_char_gen and the bound checker are compiled before it.
*/
module control_decode_char_rotator_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DELAY = 20;
	typedef struct packed {logic [4:0] code; logic [3:0] sf;} cdr_row_t;
	cdr_row_t rows [8] = '{'{5'h07, 4'h1}, '{5'h09, 4'h2}, '{5'h0B, 4'h4}, '{5'h0C, 4'h8},
		'{5'h00, 4'h0}, '{5'h10, 4'h0}, '{5'h1E, 4'h0}, '{5'h1F, 4'h0}};
	logic [8:0] rot_exp [4] = '{9'h158, 9'h085, 9'h0A2, 9'h02A};
	logic sys_clk = 1'b0, nrst = 1'b0, strobe = 1'b0, home_n = 1'b1, initialise = 1'b0, bypass = 1'b0;
	logic [3:0] row_idx = 4'h5;
	logic [2:0] col_idx = 3'h3;
	cdr_pkg::cdr_code_t code = 5'h00;
	cdr_pkg::cdr_glyph_t glyph;
	cdr_pkg::cdr_stroke_t stroke;
	logic [31:0] ctrl_char;
	logic [3:0] special_func;
	logic control_complete;
	int n_mismatch = 0, num_checks = 0;
	always #2 sys_clk = ~sys_clk;
	cdr_char_gen gen (.row_idx(row_idx), .col_idx(col_idx), .glyph(glyph));
	cdr_top #(.COMPLETE_DELAY(DELAY)) dut (.sys_clk(sys_clk), .nrst(nrst), .control_execute_strobe(strobe),
		.recv_code(code), .home_n(home_n), .initialise(initialise), .rotator_bypass(bypass), .glyph(glyph),
		.ctrl_char(ctrl_char), .special_func(special_func), .control_complete(control_complete), .stroke(stroke));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task send(input logic [4:0] c);
		@(negedge sys_clk);
		strobe = 1'b1;
		code = c;
		initialise = 1'b0;
		@(negedge sys_clk);
		chk(ctrl_char, 32'h00000001 << c);
		strobe = 1'b0;
	endtask
	task wait_done;
		logic seen;
		seen = 1'b0;
		repeat (DELAY - 1) begin
			@(negedge sys_clk);
			seen |= control_complete;
		end
		chk(32'(seen), 32'h0);
		@(negedge sys_clk);
		chk(32'(control_complete), 32'h1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(negedge sys_clk);
		chk(stroke, 9'h100);
		nrst = 1'b1;
		foreach (rows[i]) begin
			send(rows[i].code);
			chk(special_func, rows[i].sf);
			wait_done();
		end
		send(5'h07);
		repeat (8) @(negedge sys_clk);
		send(5'h07);
		wait_done();
		initialise = 1'b1;
		for (int i = 0; i < 5; i++) begin
			send(cdr_pkg::CODE_NAK);
			@(negedge sys_clk);
			chk(stroke, rot_exp[(i + 1) % 4]);
		end
		home_n = 1'b0;
		@(negedge sys_clk);
		home_n = 1'b1;
		@(negedge sys_clk);
		chk(stroke, 9'h158);
		send(cdr_pkg::CODE_NAK);
		send(cdr_pkg::CODE_US);
		@(negedge sys_clk);
		chk(stroke, 9'h158);
		send(cdr_pkg::CODE_NAK);
		bypass = 1'b1;
		@(negedge sys_clk);
		chk(stroke, 9'h158);
		test_done();
	end
	initial begin
		#20000;
		n_mismatch++;
		test_done();
	end
endmodule // control_decode_char_rotator_tb
